//--- rtl/adcc_pkg.sv
// shared constants of the conversion control block: map, fields, resets, timing
// assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus
`default_nettype none

package adcc_pkg;
  // system clock and conversion clock rates
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RATE0_KHZ = 256;
  localparam int unsigned RATE1_KHZ = 128;
  localparam int unsigned RATE2_KHZ = 64;
  localparam int unsigned RATE3_KHZ = 32;
  // system cycles per conversion clock period (rounded down)
  localparam int unsigned DIV0_CYC = CLK_HZ / (RATE0_KHZ * 1000);
  localparam int unsigned DIV1_CYC = CLK_HZ / (RATE1_KHZ * 1000);
  localparam int unsigned DIV2_CYC = CLK_HZ / (RATE2_KHZ * 1000);
  localparam int unsigned DIV3_CYC = CLK_HZ / (RATE3_KHZ * 1000);
  localparam int unsigned CONV_PERIODS = 12;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned CHAN_COUNT = 24;

  // register indices; byte address is four times the index
  localparam int unsigned IDX_CHAN_SEL = 'h0A;
  localparam int unsigned IDX_RES_LOW = 'h0B;
  localparam int unsigned IDX_RES_HIGH = 'h0C;
  localparam int unsigned IDX_CLK_CTRL = 'h0D;
  localparam int unsigned IDX_FUNC_EN = 'h10;
  localparam int unsigned IDX_IRQ_STAT = 'h11;
  localparam int unsigned IDX_IRQ_MASK = 'h12;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'(IDX_CHAN_SEL * 4);
  localparam logic [7:0] ADDR_RES_LOW = 8'(IDX_RES_LOW * 4);
  localparam logic [7:0] ADDR_RES_HIGH = 8'(IDX_RES_HIGH * 4);
  localparam logic [7:0] ADDR_CLK_CTRL = 8'(IDX_CLK_CTRL * 4);
  localparam logic [7:0] ADDR_FUNC_EN = 8'(IDX_FUNC_EN * 4);
  localparam logic [7:0] ADDR_IRQ_STAT = 8'(IDX_IRQ_STAT * 4);
  localparam logic [7:0] ADDR_IRQ_MASK = 8'(IDX_IRQ_MASK * 4);

  // field positions
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned CHAN_MSB = 4;
  localparam int unsigned EXT_SEL_BIT = 3;
  localparam int unsigned PS_MSB = 1;
  localparam int unsigned LOW_RES_LSB = 6;
  localparam int unsigned IRQ_DONE_BIT = 0;

  // reset values
  localparam logic [7:0] RST_CHAN_SEL = 8'h1F;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CLK_CTRL = 8'h00;
  localparam logic [7:0] RST_FUNC_EN = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
endpackage

`default_nettype wire

//--- rtl/adcc_clkgen.sv
// conversion clock tick generator: one pulse per selected conversion period
// assumes i_run rises with a start so the first tick comes one full period later
`default_nettype none

module adcc_clkgen #(
  parameter int unsigned DIV0 = adcc_pkg::DIV0_CYC,
  parameter int unsigned DIV1 = adcc_pkg::DIV1_CYC,
  parameter int unsigned DIV2 = adcc_pkg::DIV2_CYC,
  parameter int unsigned DIV3 = adcc_pkg::DIV3_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control
  input wire logic i_run,
  input wire logic [1:0] i_sel,
  // tick out
  output logic o_tick
);
  logic [15:0] cnt_r;
  logic [15:0] limit;

  // period length picked by the captured prescaler setting
  always_comb begin
    case (i_sel)
      2'h0: limit = 16'(DIV0 - 1);
      2'h1: limit = 16'(DIV1 - 1);
      2'h2: limit = 16'(DIV2 - 1);
      default: limit = 16'(DIV3 - 1);
    endcase
  end

  // free count while running, restart when stopped
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_run) begin
      cnt_r <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt_r == limit) begin
      cnt_r <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

//--- rtl/adcc_sar.sv
// successive approximation sequencer: sample, ten decisions, transfer
// assumes one tick per conversion period and a filtered comparator level
`default_nettype none

module adcc_sar (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic i_cmp,
  // status and result
  output logic o_busy,
  output logic o_done,
  output logic o_sample,
  output logic [9:0] o_trial,
  output logic [9:0] o_result
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DECIDE, ST_XFER} adcc_sar_state_t;
  adcc_sar_state_t state_r;
  logic [3:0] bit_r;

  // one period sampling, one per bit, one period to hand over
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      o_trial <= 10'h000;
      o_result <= 10'h000;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_sample <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (i_start) begin
            state_r <= ST_SAMPLE;
            o_busy <= 1'b1;
            o_sample <= 1'b1;
            o_trial <= 10'h000;
          end
        end
        ST_SAMPLE: begin
          if (i_tick) begin
            state_r <= ST_DECIDE;
            o_sample <= 1'b0;
            bit_r <= 4'h9;
            o_trial <= 10'h200;
          end
        end
        ST_DECIDE: begin
          if (i_tick) begin
            // keep the trial bit when the input is not below the trial level
            o_trial[bit_r] <= i_cmp;
            if (bit_r == 4'h0) begin
              state_r <= ST_XFER;
            end else begin
              o_trial[bit_r - 4'h1] <= 1'b1;
              bit_r <= bit_r - 4'h1;
            end
          end
        end
        ST_XFER: begin
          if (i_tick) begin
            state_r <= ST_IDLE;
            o_result <= o_trial;
            o_done <= 1'b1;
            o_busy <= 1'b0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

//--- rtl/adcc_top.sv
// conversion control: register file on Avalon-MM, channel routing, sequencing
// assumes an analog mux with one enable per pin and a comparator on a pin
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`default_nettype none

module adcc_top #(
  parameter int unsigned DIV0 = adcc_pkg::DIV0_CYC,
  parameter int unsigned DIV1 = adcc_pkg::DIV1_CYC,
  parameter int unsigned DIV2 = adcc_pkg::DIV2_CYC,
  parameter int unsigned DIV3 = adcc_pkg::DIV3_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // interrupt
  output logic o_irq,
  // analog front end
  output logic [23:0] o_ana_chan_en,
  output logic o_ana_sample,
  output logic [9:0] o_ana_dac,
  input wire logic i_ana_cmp
);
  // register state
  logic [7:0] chan_sel_r;
  logic [7:0] res_low_r;
  logic [7:0] res_high_r;
  logic [7:0] clk_ctrl_r;
  logic [7:0] func_en_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic [7:0] irq_stat_nxt;

  // captured conversion settings
  logic [4:0] chan_cap_r;
  logic [1:0] ps_cap_r;

  // bus handshake
  logic req;
  logic commit;
  logic wr_ok;
  logic rd_ok;
  logic ext_sel;
  logic hit_conv;
  logic [7:0] rd_byte;

  // per-register write and read strobes
  logic wr_chan;
  logic wr_clk;
  logic wr_func;
  logic wr_mask;
  logic rd_stat;

  // conversion control
  logic start;
  logic sar_busy;
  logic sar_done;
  logic done_d_r;
  logic tick;
  logic sar_sample;
  logic [9:0] sar_trial;
  logic [9:0] sar_result;

  // comparator synchroniser and filter
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic cmp_s3_r;
  logic cmp_r;

  // channel decode
  logic [23:0] chan_hot;

  // a request is accepted at the edge where waitrequest is seen low
  assign req = i_avs_read | i_avs_write;
  assign commit = req & ~o_avs_waitrequest;
  assign wr_ok = commit & i_avs_write & i_avs_byteenable[0];
  assign rd_ok = commit & i_avs_read;

  // converter window shared with other registers, open on extra select
  assign ext_sel = func_en_r[adcc_pkg::EXT_SEL_BIT];
  assign hit_conv = ext_sel;

  // write strobes per register
  assign wr_chan = wr_ok & hit_conv & (i_avs_address == adcc_pkg::ADDR_CHAN_SEL);
  assign wr_clk = wr_ok & hit_conv & (i_avs_address == adcc_pkg::ADDR_CLK_CTRL);
  assign wr_func = wr_ok & (i_avs_address == adcc_pkg::ADDR_FUNC_EN);
  assign wr_mask = wr_ok & (i_avs_address == adcc_pkg::ADDR_IRQ_MASK);
  assign rd_stat = rd_ok & (i_avs_address == adcc_pkg::ADDR_IRQ_STAT);

  // start only on a zero-to-one write of the flag while idle
  assign start = wr_chan & i_avs_writedata[adcc_pkg::FLAG_BIT]
                 & ~chan_sel_r[adcc_pkg::FLAG_BIT] & ~sar_busy;

  // read multiplexer; unmapped or closed window reads zero
  always_comb begin
    rd_byte = 8'h00;
    case (i_avs_address)
      adcc_pkg::ADDR_CHAN_SEL: rd_byte = hit_conv ? chan_sel_r : 8'h00;
      adcc_pkg::ADDR_RES_LOW: rd_byte = hit_conv ? res_low_r : 8'h00;
      adcc_pkg::ADDR_RES_HIGH: rd_byte = hit_conv ? res_high_r : 8'h00;
      adcc_pkg::ADDR_CLK_CTRL: rd_byte = hit_conv ? clk_ctrl_r : 8'h00;
      adcc_pkg::ADDR_FUNC_EN: rd_byte = func_en_r;
      adcc_pkg::ADDR_IRQ_STAT: rd_byte = irq_stat_r;
      adcc_pkg::ADDR_IRQ_MASK: rd_byte = irq_mask_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait cycle, then a single low cycle carrying the answer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (req && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= {24'h00_0000, rd_byte};
    end else begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
  end

  // channel field and start flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      chan_sel_r <= adcc_pkg::RST_CHAN_SEL;
    end else begin
      if (wr_chan) begin
        chan_sel_r[adcc_pkg::CHAN_MSB:0] <= i_avs_writedata[adcc_pkg::CHAN_MSB:0];
      end
      if (start) begin
        chan_sel_r[adcc_pkg::FLAG_BIT] <= 1'b1;
      end else if (done_d_r) begin
        chan_sel_r[adcc_pkg::FLAG_BIT] <= 1'b0;
      end
    end
  end

  // prescaler setting, upper bits kept at zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      clk_ctrl_r <= adcc_pkg::RST_CLK_CTRL;
    end else if (wr_clk) begin
      clk_ctrl_r[adcc_pkg::PS_MSB:0] <= i_avs_writedata[adcc_pkg::PS_MSB:0];
    end
  end

  // extra register select and interrupt mask
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      func_en_r <= adcc_pkg::RST_FUNC_EN;
      irq_mask_r <= adcc_pkg::RST_IRQ;
    end else begin
      if (wr_func) begin
        func_en_r <= i_avs_writedata[7:0];
      end
      if (wr_mask) begin
        irq_mask_r <= i_avs_writedata[7:0];
      end
    end
  end

  // capture channel and clock choice at the start write
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      chan_cap_r <= adcc_pkg::RST_CHAN_SEL[adcc_pkg::CHAN_MSB:0];
      ps_cap_r <= 2'h0;
    end else if (start) begin
      chan_cap_r <= i_avs_writedata[adcc_pkg::CHAN_MSB:0];
      ps_cap_r <= clk_ctrl_r[adcc_pkg::PS_MSB:0];
    end
  end

  // conversion clock from the captured prescaler choice
  adcc_clkgen #(
    .DIV0(DIV0),
    .DIV1(DIV1),
    .DIV2(DIV2),
    .DIV3(DIV3)
  ) u_clkgen (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_run(sar_busy),
    .i_sel(ps_cap_r),
    .o_tick(tick)
  );

  // comparator pin: three stages, change taken when stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      cmp_s1_r <= i_ana_cmp;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r) begin
        cmp_r <= cmp_s3_r;
      end
    end
  end

  // twelve-period successive approximation
  adcc_sar u_sar (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(start),
    .i_tick(tick),
    .i_cmp(cmp_r),
    .o_busy(sar_busy),
    .o_done(sar_done),
    .o_sample(sar_sample),
    .o_trial(sar_trial),
    .o_result(sar_result)
  );

  // results move only at completion; flag clears one cycle later
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      res_low_r <= adcc_pkg::RST_RESULT;
      res_high_r <= adcc_pkg::RST_RESULT;
      done_d_r <= 1'b0;
    end else begin
      done_d_r <= sar_done;
      if (sar_done) begin
        res_low_r <= {sar_result[1:0], 6'h00};
        res_high_r <= sar_result[9:2];
      end
    end
  end

  // one-hot pin enable, held only during a conversion
  genvar gi;
  generate
    for (gi = 0; gi < adcc_pkg::CHAN_COUNT; gi++) begin : g_chan
      assign chan_hot[gi] = sar_busy && (chan_cap_r == 5'(gi));
    end
  endgenerate

  // analog outputs from flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ana_chan_en <= 24'h00_0000;
      o_ana_sample <= 1'b0;
      o_ana_dac <= 10'h000;
    end else begin
      o_ana_chan_en <= chan_hot;
      o_ana_sample <= sar_sample;
      o_ana_dac <= sar_trial;
    end
  end

  // sticky done status: set beats the read clear
  always_comb begin
    irq_stat_nxt = rd_stat ? 8'h00 : irq_stat_r;
    if (done_d_r) begin
      irq_stat_nxt[adcc_pkg::IRQ_DONE_BIT] = 1'b1;
    end
  end

  // status register and interrupt level
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_stat_r <= adcc_pkg::RST_IRQ;
      o_irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      o_irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end
endmodule

`default_nettype wire

//--- verification/adcc_properties.sv
// checker for the conversion control top: bus answer, read masks, pin routing
// assumes it is bound to adcc_top and sees only its ports
`default_nettype none

module adcc_chk #(
  parameter int unsigned DIV0 = 4,
  parameter int unsigned DIV1 = 5,
  parameter int unsigned DIV2 = 6,
  parameter int unsigned DIV3 = 7
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // interrupt and front end
  input wire logic o_irq,
  input wire logic [23:0] o_ana_chan_en,
  input wire logic o_ana_sample,
  input wire logic [9:0] o_ana_dac,
  input wire logic i_ana_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_done;
  logic rd_done;
  logic ext_r;
  logic [7:0] mask_r;
  logic [1:0] ps_r;
  logic [1:0] ps_hold_r;
  int unsigned samp_cnt_r;
  int unsigned div_now;

  // completed transfers and the period length captured at sampling
  assign wr_done = !o_avs_waitrequest && i_avs_write && i_avs_byteenable[0];
  assign rd_done = !o_avs_waitrequest && i_avs_read;
  assign div_now = ps_hold_r == 2'h0 ? DIV0 : ps_hold_r == 2'h1 ? DIV1 :
                   ps_hold_r == 2'h2 ? DIV2 : DIV3;

  // shadows of select bit, mask and prescaler; sample length counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ext_r <= 1'b0;
      mask_r <= 8'h00;
      ps_r <= 2'h0;
      ps_hold_r <= 2'h0;
      samp_cnt_r <= 0;
    end else begin
      if (wr_done && i_avs_address == adcc_pkg::ADDR_FUNC_EN) ext_r <= i_avs_writedata[3];
      if (wr_done && i_avs_address == adcc_pkg::ADDR_IRQ_MASK) mask_r <= i_avs_writedata[7:0];
      if (wr_done && ext_r && i_avs_address == adcc_pkg::ADDR_CLK_CTRL) begin
        ps_r <= i_avs_writedata[1:0];
      end
      if (o_ana_sample && samp_cnt_r == 0) ps_hold_r <= ps_r;
      samp_cnt_r <= o_ana_sample ? samp_cnt_r + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_req_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_one_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  property p_bus_ack;
    s_req_wait |=> s_one_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");
  property p_idle_data;
    o_avs_waitrequest || i_avs_write |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data upper bits set");
  property p_hidden;
    rd_done && !ext_r && i_avs_address inside {[8'h28:8'h34]} |-> o_avs_readdata == 32'h0;
  endproperty
  a_hidden: assert property (p_hidden) else $error("converter register visible");
  property p_low_mask;
    rd_done && i_avs_address == adcc_pkg::ADDR_RES_LOW |-> o_avs_readdata[5:0] == 6'h0;
  endproperty
  a_low_mask: assert property (p_low_mask) else $error("low result spare bits set");
  property p_ctrl_mask;
    rd_done && i_avs_address == adcc_pkg::ADDR_CLK_CTRL |-> o_avs_readdata[7:3] == 5'h0;
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("control spare bits set");
  property p_sel_mask;
    rd_done && i_avs_address == adcc_pkg::ADDR_CHAN_SEL |-> o_avs_readdata[6:5] == 2'h0;
  endproperty
  a_sel_mask: assert property (p_sel_mask) else $error("select spare bits set");
  property p_onehot;
    $onehot0(o_ana_chan_en);
  endproperty
  a_onehot: assert property (p_onehot) else $error("several pins enabled");
  property p_pin_hold;
    o_ana_chan_en != 24'h0 |=> o_ana_chan_en == $past(o_ana_chan_en) || o_ana_chan_en == 24'h0;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin changed mid conversion");
  property p_samp_len;
    // registered tick adds one cycle to the sampling period
    $fell(o_ana_sample) |-> samp_cnt_r == div_now + 1;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample period length wrong");
  property p_irq_mask;
    o_irq |-> $past(mask_r) != 8'h00;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
  property p_irq_clear;
    rd_done && i_avs_address == adcc_pkg::ADDR_IRQ_STAT |=> ##1 !o_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt kept after read");
endmodule

bind adcc_top adcc_chk #(.DIV0(DIV0), .DIV1(DIV1), .DIV2(DIV2), .DIV3(DIV3)) adcc_chk_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_ana_chan_en(o_ana_chan_en),
  .o_ana_sample(o_ana_sample), .o_ana_dac(o_ana_dac), .i_ana_cmp(i_ana_cmp));

`default_nettype wire

//--- verification/adcc_ana_model.sv
// behavioural analog mux and comparator facing the converter pins
// assumes one-hot pin enables; each channel carries a fixed test level
`default_nettype none

module adcc_ana_model (
  // clock
  input wire logic i_clk_sys,
  // pins from the converter
  input wire logic [23:0] i_chan_en,
  input wire logic [9:0] i_dac,
  // comparator out
  output logic o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] lvl;
  logic flip_r = 1'b0;

  // level of the one pin routed through
  always_comb begin
    lvl = 10'h000;
    for (int k = 0; k < 24; k++) begin
      if (i_chan_en[k]) lvl = 10'(k * 43 + 5);
    end
  end

  // an unrouted input wanders every cycle
  always_ff @(posedge i_clk_sys) flip_r <= !flip_r;
  assign o_cmp = (i_chan_en != 24'h0) ? (lvl >= i_dac) : flip_r;
endmodule

`default_nettype wire

//--- verification/adcc_top_test.sv
// self-checking bench for the conversion control top
// assumes small divider parameters and the behavioural analog model
`default_nettype none

module adcc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // at least six cycles per period: pin, dac flop and three sync stages precede a decision
  localparam int unsigned DV[4] = '{8, 9, 10, 11};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitreq, irq, sample, cmp;
  logic [23:0] chan_en;
  logic [9:0] dac;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  // clock
  always #2.5 clk = !clk;

  // design and analog partner
  adcc_top #(.DIV0(DV[0]), .DIV1(DV[1]), .DIV2(DV[2]), .DIV3(DV[3])) adcc_top_inst (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
    .o_ana_chan_en(chan_en), .o_ana_sample(sample), .o_ana_dac(dac), .i_ana_cmp(cmp));
  adcc_ana_model adcc_ana_model_inst (.i_clk_sys(clk), .i_chan_en(chan_en), .i_dac(dac),
    .o_cmp(cmp));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one held transfer, then one idle edge before the next
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr_en <= w;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // reset values, hiding, spare bits, read-only results, byte enable
  task automatic t_regs();
    rc(adcc_pkg::ADDR_CHAN_SEL, 32'h0);
    wr(adcc_pkg::ADDR_FUNC_EN, 32'h08);
    rc(adcc_pkg::ADDR_CHAN_SEL, 32'h1F);
    rc(adcc_pkg::ADDR_RES_LOW, 32'h0);
    rc(adcc_pkg::ADDR_RES_HIGH, 32'h0);
    rc(adcc_pkg::ADDR_CLK_CTRL, 32'h0);
    wr(adcc_pkg::ADDR_CLK_CTRL, 32'hFF);
    rc(adcc_pkg::ADDR_CLK_CTRL, 32'h03);
    be <= 4'hE;
    wr(adcc_pkg::ADDR_CLK_CTRL, 32'h00);
    be <= 4'hF;
    rc(adcc_pkg::ADDR_CLK_CTRL, 32'h03);
    wr(adcc_pkg::ADDR_CHAN_SEL, 32'h6A);
    rc(adcc_pkg::ADDR_CHAN_SEL, 32'h0A);
    wr(adcc_pkg::ADDR_RES_LOW, 32'hFF);
    rc(adcc_pkg::ADDR_RES_LOW, 32'h0);
    rc(8'hFC, 32'h0);
  endtask

  // one conversion; mid asks for channel and clock rewrites while it runs
  task automatic t_conv(input int ps, input int ch, input logic mid);
    int c0;
    logic [9:0] v;
    logic [31:0] pin;
    logic [31:0] sel;
    v = 10'(ch * 43 + 5);
    pin = (ch < 24) ? (32'h1 << ch) : 32'h0;
    sel = mid ? 32'h0C : 32'(ch);
    wr(adcc_pkg::ADDR_CLK_CTRL, 32'(ps));
    wr(adcc_pkg::ADDR_CHAN_SEL, 32'h80 | 32'(ch));
    c0 = cycles;
    rc(adcc_pkg::ADDR_CHAN_SEL, 32'h80 | 32'(ch));
    chk(32'(chan_en), pin);
    if (mid) begin
      wr(adcc_pkg::ADDR_CHAN_SEL, 32'h8C);
      wr(adcc_pkg::ADDR_CLK_CTRL, 32'h03);
      chk(32'(chan_en), pin);
    end
    while (irq !== 1'b1 && cycles - c0 < 2000) @(posedge clk);
    chk(32'(cycles - c0 >= 12 * DV[ps] && cycles - c0 <= 12 * DV[ps] + 12), 32'h1);
    rc(adcc_pkg::ADDR_CHAN_SEL, sel);
    rc(adcc_pkg::ADDR_RES_HIGH, 32'(v[9:2]));
    rc(adcc_pkg::ADDR_RES_LOW, 32'({v[1:0], 6'h00}));
    rc(adcc_pkg::ADDR_IRQ_STAT, 32'h1);
    rc(adcc_pkg::ADDR_IRQ_STAT, 32'h0);
  endtask

  // masked event on a channel with no pin behind it
  task automatic t_mask();
    logic [31:0] q;
    wr(adcc_pkg::ADDR_IRQ_MASK, 32'h00);
    wr(adcc_pkg::ADDR_CHAN_SEL, 32'h9E);
    chk(32'(chan_en), 32'h0);
    q = 32'h80;
    while (q[7] !== 1'b0) bus(1'b0, adcc_pkg::ADDR_CHAN_SEL, 32'h0, q);
    chk(32'(irq), 32'h0);
    rc(adcc_pkg::ADDR_IRQ_STAT, 32'h1);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    wr(adcc_pkg::ADDR_IRQ_MASK, 32'h01);
    for (int p = 0; p < 4; p++) begin
      t_conv(p, p * 7 + 2, 1'b0);
    end
    t_conv(0, 5, 1'b1);
    t_mask();
    summarize();
  end
endmodule

`default_nettype wire
